// ---- design/wdg_pkg.sv ----
// Package of register map, field positions and reset values for the watchdog block
package wdg_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] WDG_OFF_RELOAD  = 12'h000;  // count_reload_value
    localparam logic [11:0] WDG_OFF_VALUE   = 12'h004;  // live_count_readout
    localparam logic [11:0] WDG_OFF_CTRL    = 12'h008;  // guard_control
    localparam logic [11:0] WDG_OFF_ICLR    = 12'h00C;  // irq_clear_port
    localparam logic [11:0] WDG_OFF_RIS     = 12'h010;  // raw interrupt status
    localparam logic [11:0] WDG_OFF_MIS     = 12'h014;  // masked_irq_flag
    localparam logic [11:0] WDG_OFF_TEST    = 12'h418;  // guard_test_control
    localparam logic [11:0] WDG_OFF_EVSTAT  = 12'h500;  // sticky event status
    localparam logic [11:0] WDG_OFF_EVMASK  = 12'h504;  // event mask
    localparam logic [11:0] WDG_OFF_GATE    = 12'h508;  // run_clock_gate_zero bit
    localparam logic [11:0] WDG_OFF_SRST    = 12'h50C;  // module_soft_reset bit
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WDG_CTL_INTEN  = 0;   // Counter and interrupt enable
    localparam int WDG_CTL_RSTOUT = 1;   // reset_output_enable
    localparam int WDG_CTL_NMI    = 2;   // Deliver time-out as NMI
    localparam int WDG_TEST_STALL = 8;   // Hold count under debug halt
    localparam int WDG_EV_TMO     = 0;   // Event: first time-out
    localparam int WDG_EV_RST     = 1;   // Event: second time-out
    localparam int WDG_EV_W       = 2;   // Event vector width
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] WDG_RELOAD_RST = 32'hFFFFFFFF;
    localparam logic [2:0]  WDG_CTRL_RST   = 3'h0;
endpackage

// ---- design/wdg_counter.sv ----
// Down counter with reload and stall for the watchdog block
`timescale 1ns/1ns
module wdg_counter
    import wdg_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic         stall,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count_ff,
    output logic              zero_pulse_ff
);
    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    // Load wins over stall so a debugger write always lands
    always_ff @(posedge clock) begin
        if (rst) begin
            count_ff      <= '1;
            zero_pulse_ff <= 1'b0;
        end else begin
            zero_pulse_ff <= 1'b0;
            if (load) begin
                count_ff <= load_val;
            end else if (run && tick && !stall) begin
                if (count_ff == '0) begin
                    count_ff      <= load_val;
                    zero_pulse_ff <= 1'b1;
                end else begin
                    count_ff <= count_ff - 1'b1;
                end
            end
        end
    end
    a_stall_holds: assert property (@(posedge clock) disable iff (rst)
        (stall && !load) |=> (count_ff == $past(count_ff)))
        else $error("count moved while stalled");
    a_load_applies: assert property (@(posedge clock) disable iff (rst)
        load |=> (count_ff == $past(load_val)))
        else $error("reload not applied");
endmodule

// ---- design/wdg_top.sv ----
// Watchdog timer with NMI and reset output behind an APB slave
//
// Summary of operation
// - Reload write restarts count from value
// - Any write to clear port clears irq
// - Second uncleared time-out requests system reset
// - Reset never asserted while reset enable clear
// - NMI mode sends time-out as NMI
// - Masked status set also in NMI mode
// - Reload writes work while stalled
// - Reload readback returns last written value
// - Count readout is a coherent snapshot
// - Counts on precise oscillator tick independently; here the tick is a synchronous enable in the bus clock domain
// - Clock gate bit alone enables module; here counting also needs the CTRL enable bit
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module wdg_top
    import wdg_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_tick,
    input  wire logic        use_precise_osc,
    input  wire logic        dbg_halt,
    output logic             irq_out,
    output logic             nmi_out,
    output logic             sys_reset_req,
    output logic             event_irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic             wr_en;           // APB write access phase
    logic             rd_en;           // APB read access phase
    logic [31:0]      reload_ff;       // count_reload_value
    logic [2:0]       ctrl_ff;         // guard_control
    logic             stall_ff;        // guard_test_control stall bit
    logic             gate_ff;         // run_clock_gate_zero bit
    logic             srst_ff;         // module_soft_reset bit
    logic             ris_ff;          // Raw time-out status
    logic             rst_req_ff;      // Latched reset request
    logic [WDG_EV_W-1:0] ev_stat_ff;   // Sticky events
    logic [WDG_EV_W-1:0] ev_mask_ff;   // Event mask
    logic [31:0]      prdata_ff;       // Read data register
    logic             mod_rst;         // Block-local reset
    logic             reload_wr;       // Reload write strobe
    logic             tick;            // Count enable
    logic [CNT_W-1:0] count;           // Live count
    logic             zero;            // Time-out pulse
    logic             tmo_first;       // First time-out
    logic             tmo_second;      // Second time-out
    logic             iclr_wr;         // Interrupt clear strobe
    logic             ack_err;         // Unmapped address

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    // Zero wait states; handshake outputs are combinational
    assign pready  = 1'b1;
    assign pslverr = psel && penable && ack_err;
    assign prdata  = prdata_ff;

    // Address check used by the error path only; the read mux decodes addresses itself
    function automatic logic wdg_mapped(input logic [11:0] a);
        wdg_mapped = (a == WDG_OFF_RELOAD) || (a == WDG_OFF_VALUE) || (a == WDG_OFF_CTRL)
                  || (a == WDG_OFF_ICLR) || (a == WDG_OFF_RIS) || (a == WDG_OFF_MIS)
                  || (a == WDG_OFF_TEST) || (a == WDG_OFF_EVSTAT) || (a == WDG_OFF_EVMASK)
                  || (a == WDG_OFF_GATE) || (a == WDG_OFF_SRST);
    endfunction
    assign ack_err = !wdg_mapped(paddr);

    // soft reset bit holds block in reset
    assign mod_rst   = rst || srst_ff;
    assign reload_wr = wr_en && (paddr == WDG_OFF_RELOAD);
    assign iclr_wr   = wr_en && (paddr == WDG_OFF_ICLR);

    // ------------------------------------------------------------
    // Gate and soft reset bits (system reset only)
    // ------------------------------------------------------------
    // These survive the soft reset so software can release it
    always_ff @(posedge clock) begin
        if (rst) begin
            gate_ff <= 1'b0;
            srst_ff <= 1'b0;
        end else begin
            if (wr_en && paddr == WDG_OFF_GATE) begin
                gate_ff <= pwdata[0];
            end
            if (wr_en && paddr == WDG_OFF_SRST) begin
                srst_ff <= pwdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (mod_rst) begin
            reload_ff <= WDG_RELOAD_RST;
            ctrl_ff   <= WDG_CTRL_RST;
            stall_ff  <= 1'b0;
            ev_mask_ff <= '0;
        end else begin
            // reload holds exactly what was written
            if (reload_wr) begin
                reload_ff <= pwdata;
            end
            if (wr_en && paddr == WDG_OFF_CTRL) begin
                ctrl_ff <= pwdata[2:0];
            end
            if (wr_en && paddr == WDG_OFF_TEST) begin
                stall_ff <= pwdata[WDG_TEST_STALL];
            end
            if (wr_en && paddr == WDG_OFF_EVMASK) begin
                ev_mask_ff <= pwdata[WDG_EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // tick source is the precise oscillator or every clock
    // gate bit enables the tick, no other peripheral involved; counting also needs the CTRL enable bit
    // The oscillator tick is a synchronous enable, so the count lives in
    // the bus domain and readout is always coherent.
    assign tick = gate_ff && (use_precise_osc ? osc_tick : 1'b1);

    wdg_counter #(
        .W (CNT_W)
    ) u_cnt (
        .clock         (clock),
        .rst           (mod_rst),
        .run           (ctrl_ff[WDG_CTL_INTEN]),
        .tick          (tick),
        .stall         (stall_ff && dbg_halt),
        .load          (reload_wr),
        .load_val      (reload_wr ? pwdata[CNT_W-1:0] : reload_ff[CNT_W-1:0]),
        .count_ff      (count),
        .zero_pulse_ff (zero)
    );

    assign tmo_first  = zero && !ris_ff;
    assign tmo_second = zero && ris_ff;

    // ------------------------------------------------------------
    // Time-out status and reset request
    // ------------------------------------------------------------
    // Set wins over a same-cycle clear so no time-out is lost
    always_ff @(posedge clock) begin
        if (mod_rst) begin
            ris_ff <= 1'b0;
        end else if (zero) begin
            ris_ff <= 1'b1;
        end else if (iclr_wr) begin
            ris_ff <= 1'b0;
        end
    end

    // Reset request is sticky until the block itself is reset
    always_ff @(posedge clock) begin
        if (mod_rst) begin
            rst_req_ff <= 1'b0;
        end else if (tmo_second && ctrl_ff[WDG_CTL_RSTOUT]) begin
            rst_req_ff <= 1'b1;
        end
    end

    // gated by reset enable at the output too
    assign sys_reset_req = rst_req_ff && ctrl_ff[WDG_CTL_RSTOUT];
    // route time-out to NMI when selected
    assign nmi_out = ris_ff && ctrl_ff[WDG_CTL_NMI];
    assign irq_out = ris_ff && !ctrl_ff[WDG_CTL_NMI];

    // ------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (mod_rst) begin
            ev_stat_ff <= '0;
        end else begin
            for (int i = 0; i < WDG_EV_W; i++) begin
                if ((i == WDG_EV_TMO && tmo_first) || (i == WDG_EV_RST && tmo_second)) begin
                    ev_stat_ff[i] <= 1'b1;
                end else if (wr_en && paddr == WDG_OFF_EVSTAT && pwdata[i]) begin
                    ev_stat_ff[i] <= 1'b0;
                end
            end
        end
    end
    assign event_irq = |(ev_stat_ff & ev_mask_ff);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_ff <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == WDG_OFF_RELOAD) begin
                prdata_ff <= reload_ff;
            end else if (paddr == WDG_OFF_VALUE) begin
                prdata_ff <= 32'(count);
            end else if (paddr == WDG_OFF_CTRL) begin
                prdata_ff <= {29'h0, ctrl_ff};
            end else if (paddr == WDG_OFF_RIS) begin
                prdata_ff <= {31'h0, ris_ff};
            end else if (paddr == WDG_OFF_MIS) begin
                // masked flag set in both delivery modes
                prdata_ff <= {31'h0, ris_ff && ctrl_ff[WDG_CTL_INTEN]};
            end else if (paddr == WDG_OFF_TEST) begin
                prdata_ff <= 32'(stall_ff) << WDG_TEST_STALL;
            end else if (paddr == WDG_OFF_EVSTAT) begin
                prdata_ff <= 32'(ev_stat_ff);
            end else if (paddr == WDG_OFF_EVMASK) begin
                prdata_ff <= 32'(ev_mask_ff);
            end else if (paddr == WDG_OFF_GATE) begin
                prdata_ff <= {31'h0, gate_ff};
            end else if (paddr == WDG_OFF_SRST) begin
                prdata_ff <= {31'h0, srst_ff};
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Count enable exactly as the counter sees it; a reload write overrides it
    logic live_tick;  // Counter steps on this edge
    assign live_tick = ctrl_ff[WDG_CTL_INTEN] && tick && !(stall_ff && dbg_halt) && !reload_wr;

    // Second time-out while the reset output is enabled
    sequence s_second_tmo;
        tmo_second && ctrl_ff[WDG_CTL_RSTOUT];
    endsequence
    // Counter sits at zero and steps, so it expires now
    sequence s_expire;
        live_tick && (count == '0);
    endsequence

    a_reset_second: assert property (@(posedge clock) disable iff (mod_rst)
        s_second_tmo |=> sys_reset_req)
        else $error("no reset after second time-out");

    a_first_quiet: assert property (@(posedge clock) disable iff (mod_rst)
        (tmo_first && !rst_req_ff) |=> !rst_req_ff)
        else $error("reset requested on first time-out");

    a_reset_sticky: assert property (@(posedge clock) disable iff (mod_rst)
        rst_req_ff |=> rst_req_ff)
        else $error("reset request dropped");

    a_reset_gated: assert property (@(posedge clock) disable iff (rst)
        !ctrl_ff[WDG_CTL_RSTOUT] |-> !sys_reset_req)
        else $error("reset asserted while disabled");

    a_clear_any: assert property (@(posedge clock) disable iff (mod_rst)
        (iclr_wr && !zero) |=> !ris_ff)
        else $error("clear write ignored");

    a_clear_out: assert property (@(posedge clock) disable iff (mod_rst)
        (iclr_wr && !zero) |=> (!irq_out && !nmi_out))
        else $error("interrupt output stayed after clear");

    a_nmi_route: assert property (@(posedge clock) disable iff (mod_rst)
        (zero && ctrl_ff[WDG_CTL_NMI]) |=> nmi_out)
        else $error("time-out not sent as NMI");

    a_mis_read: assert property (@(posedge clock) disable iff (rst)
        (psel && !penable && !pwrite && (paddr == WDG_OFF_MIS) && ris_ff && ctrl_ff[WDG_CTL_INTEN]) |=> prdata[0])
        else $error("masked flag read as clear");

    a_zero_sets: assert property (@(posedge clock) disable iff (mod_rst)
        zero |=> ris_ff)
        else $error("time-out not latched");

    a_expire: assert property (@(posedge clock) disable iff (mod_rst)
        s_expire |=> (zero && (count == $past(reload_ff[CNT_W-1:0]))))
        else $error("expiry did not pulse and reload");

    a_count_step: assert property (@(posedge clock) disable iff (mod_rst)
        (live_tick && (count != '0)) |=> (count == $past(count) - 1'b1))
        else $error("count did not step by one");

    a_hold_idle: assert property (@(posedge clock) disable iff (mod_rst)
        (!live_tick && !reload_wr) |=> (count == $past(count)))
        else $error("count moved without a tick");

    a_event_set: assert property (@(posedge clock) disable iff (mod_rst)
        tmo_first |=> ev_stat_ff[WDG_EV_TMO])
        else $error("first time-out event not logged");

    a_stall_load: assert property (@(posedge clock) disable iff (mod_rst)
        (reload_wr && stall_ff && dbg_halt) |=> (count == $past(pwdata[CNT_W-1:0])))
        else $error("reload lost while stalled");

    a_reload_rb: assert property (@(posedge clock) disable iff (mod_rst)
        reload_wr |=> (reload_ff == $past(pwdata)))
        else $error("reload readback wrong");

    a_value_snap: assert property (@(posedge clock) disable iff (rst)
        (psel && !penable && !pwrite && paddr == WDG_OFF_VALUE) |=> (prdata == 32'($past(count))))
        else $error("count readout not coherent");

    // oscillator mode counts on ticks only
    a_tick_only: assert property (@(posedge clock) disable iff (mod_rst)
        (use_precise_osc && !osc_tick && !reload_wr) |=> (count == $past(count)))
        else $error("count moved between oscillator ticks");

    // gate bit off keeps counter still
    a_gate_idle: assert property (@(posedge clock) disable iff (mod_rst)
        (!gate_ff && !reload_wr) |=> (count == $past(count)))
        else $error("counter ran while gated");
endmodule

// ---- verif/wdg_irq_sink.sv ----
// Model of the interrupt controller and reset logic facing the watchdog
`timescale 1ns/1ns
module wdg_irq_sink #(
    parameter int DIV = 4  // Clocks per precise oscillator tick
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       irq_out,
    input  wire logic       nmi_out,
    input  wire logic       sys_reset_req,
    output logic            osc_tick,
    output logic      [7:0] nmi_cnt_ff,
    output logic            rst_seen_ff
);
    // --------------------------------------------------------
    // Precise oscillator divider and event capture
    // --------------------------------------------------------
    logic [7:0] div_ff;  // Divider phase
    logic       nmi_d_ff; // Last NMI level, for edge detect
    always_ff @(posedge clock) begin
        div_ff   <= rst ? 8'h00 : (div_ff == DIV - 1) ? 8'h00 : div_ff + 8'h01;
        osc_tick <= !rst && (div_ff == 8'h00);
    end
    // Count NMI entries; a reset request is latched as the system would
    always_ff @(posedge clock) begin
        nmi_d_ff    <= !rst && nmi_out;
        nmi_cnt_ff  <= rst ? 8'h00 : nmi_cnt_ff + {7'h00, nmi_out && !nmi_d_ff};
        rst_seen_ff <= !rst && (rst_seen_ff || sys_reset_req);
    end
endmodule

// ---- verif/wdg_top_tb.sv ----
// Self-checking bench for the watchdog block
`timescale 1ns/1ns
module wdg_top_tb;
    import wdg_pkg::*;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v1;
    logic pready, pslverr, osc_tick, irq_out, nmi_out, sys_reset_req, event_irq;
    logic use_precise_osc = 0, dbg_halt = 0, rst_seen;
    logic [7:0] nmi_cnt;
    logic [2:0] outs;  // irq, nmi, reset request, MSB first
    assign outs = {irq_out, nmi_out, sys_reset_req};
    logic [64:0] notes[$];  // Pending read notes: err, mask, expected
    logic [64:0] nt;
    logic [31:0] seed = 32'h00015CF6;  // 89334
    int failures = 0, cmp_count = 0, cyc = 0;
    always #5 clock = ~clock;
    wdg_top i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_tick(osc_tick), .use_precise_osc(use_precise_osc), .dbg_halt(dbg_halt),
        .irq_out(irq_out), .nmi_out(nmi_out), .sys_reset_req(sys_reset_req), .event_irq(event_irq));
    wdg_irq_sink #(.DIV(4)) i_sink (.clock(clock), .rst(rst), .irq_out(irq_out), .nmi_out(nmi_out),
        .sys_reset_req(sys_reset_req), .osc_tick(osc_tick), .nmi_cnt_ff(nmi_cnt), .rst_seen_ff(rst_seen));
    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        psel <= 0; penable <= 0;
        // One more edge so what the access edge launched is settled for the caller
        @(posedge clock);
    endtask
    // Read with a note for the monitor; mask zero with err clear means no note
    task automatic rdn(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
        input logic err = 0);
        if (m != 0 || err) notes.push_back({err, m, e});
        xfer(0, a, 32'h0);
    endtask
    // Bounded wait for one of the outputs to rise
    task automatic wait_hi(input int s, input int lim);
        for (int n = 0; n < lim && outs[s] !== 1'b1; n++) @(posedge clock);
        // Let the partner model latch the level too
        @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Monitor: completed reads are matched to the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && notes.size() > 0) begin
            nt = notes.pop_front();
            chk("read data", nt[31:0], prdata & nt[63:32]);
            chk("slave error", {31'h0, nt[64]}, {31'h0, pslverr});
        end
    end
    // Watchdog on the bench itself
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst <= 0;
        rdn(WDG_OFF_RELOAD, WDG_RELOAD_RST, 32'hFFFFFFFF);
        rdn(WDG_OFF_CTRL, 32'h0, 32'h7);
        rdn(12'h020, 32'h0, 32'hFFFFFFFF, 1);
        v1 = xs();
        xfer(1, WDG_OFF_RELOAD, v1);
        rdn(WDG_OFF_RELOAD, v1, 32'hFFFFFFFF);
        xfer(1, WDG_OFF_GATE, 32'h1);
        xfer(1, WDG_OFF_RELOAD, 32'h14);
        xfer(1, WDG_OFF_EVMASK, 32'h3);
        xfer(1, WDG_OFF_CTRL, 32'h1);
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        v1 = rd;
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        // gate bit together with the CTRL enable bit lets the counter run
        chk("count falls", 1, v1 <= 32'h14 && rd < v1);
        // Periodic reloads keep the time-out away
        repeat (8) begin
            xfer(1, WDG_OFF_RELOAD, 32'h14);
            repeat (5) @(posedge clock);
        end
        chk("irq under reloads", 0, irq_out);
        wait_hi(2, 100);
        chk("irq after expiry", 1, irq_out);
        rdn(WDG_OFF_MIS, 32'h1, 32'h1);
        repeat (100) @(posedge clock);
        // no reset while reset enable clear
        chk("reset req", 0, sys_reset_req);
        rdn(WDG_OFF_EVSTAT, 32'h3, 32'h3);
        chk("event irq", 1, event_irq);
        // Push the next time-out far away so no event races the clears below
        xfer(1, WDG_OFF_RELOAD, 32'h3E8);
        xfer(1, WDG_OFF_EVMASK, 32'h0);
        chk("event masked", 0, event_irq);
        xfer(1, WDG_OFF_EVMASK, 32'h3);
        xfer(1, WDG_OFF_EVSTAT, 32'h3);
        chk("event cleared", 0, event_irq);
        xfer(1, WDG_OFF_ICLR, xs());
        rdn(WDG_OFF_RIS, 32'h0, 32'h1);
        chk("irq cleared", 0, irq_out);
        xfer(1, WDG_OFF_TEST, 32'h1 << WDG_TEST_STALL);
        dbg_halt <= 1;
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        v1 = rd;
        repeat (10) @(posedge clock);
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        chk("stalled count", v1, rd);
        xfer(1, WDG_OFF_RELOAD, 32'h28);
        rdn(WDG_OFF_VALUE, 32'h28, 32'hFFFFFFFF);
        dbg_halt <= 0;
        repeat (5) @(posedge clock);
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        chk("count resumes", 1, rd < 32'h28);
        use_precise_osc <= 1;
        xfer(1, WDG_OFF_RELOAD, 32'h3E8);
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        v1 = rd;
        repeat (40) @(posedge clock);
        rdn(WDG_OFF_VALUE, 32'h0, 32'h0);
        chk("tick rate", 1, (v1 - rd) >= 8 && (v1 - rd) <= 13);
        xfer(1, WDG_OFF_SRST, 32'h1);
        xfer(1, WDG_OFF_SRST, 32'h0);
        rdn(WDG_OFF_CTRL, 32'h0, 32'h7);
        rdn(WDG_OFF_RELOAD, WDG_RELOAD_RST, 32'hFFFFFFFF);
        use_precise_osc <= 0;
        xfer(1, WDG_OFF_RELOAD, 32'h14);
        xfer(1, WDG_OFF_CTRL, 32'h7);
        wait_hi(1, 100);
        chk("nmi", 1, nmi_out);
        chk("plain irq", 0, irq_out);
        // masked flag also in NMI mode
        rdn(WDG_OFF_MIS, 32'h1, 32'h1);
        wait_hi(0, 100);
        chk("reset req", 1, sys_reset_req);
        chk("nmi seen", 1, nmi_cnt != 0 && rst_seen);
        tally_and_finish();
    end
endmodule
